// ==== bbd_core.sv ====
/*
 * bbd_core: executes the boolean and program-control instructions of
 * an 8-bit core, one instruction per START_IN, timed in machine cycles.
 * Assumes the core supplies all instruction bytes, the opcode address,
 * operand values and return address, all held steady until DONE_OUT.
 */
// Overview of operation
// - opcode 82 ANDs the addressed bit into carry; two bytes, two cycles
// - opcode B0 ANDs inverted bit into carry; bit itself unchanged
// - opcode 72 ORs the addressed bit into carry; two bytes, two cycles
// - opcode A0 ORs inverted bit into carry; bit itself unchanged
// - opcode A2 copies the addressed bit into carry in one cycle
// - opcode 92 writes carry into the addressed bit; two cycles
// - opcode 80 branches unconditionally by signed second byte
// - opcode 73 loads program counter with accumulator plus data pointer
// - opcode 60 branches on accumulator zero, 70 on nonzero
// - opcode 40 branches on carry one, 50 on carry zero
// - opcodes 20 and 30 branch on addressed bit one or zero
// - opcode 10 branches on bit one and clears that bit
// - compare opcodes branch when operands differ; three bytes, two cycles
// - decrement opcodes decrement operand, branch when result nonzero
// - far call 12 and far branch 02 take 16-bit target
// - page call and branch replace low 11 bits of following address
// - x1 opcodes: odd high nibble calls, even branches; nibble gives bits
// - relative offset is signed, added to following instruction address
// - low nibble 8..F selects working register 0..7 of active bank
// - direct byte addresses lower 128 RAM or special function registers
// - indirect uses register 0 or 1 of bank, low opcode bit selects
// - immediate byte comes from instruction byte two
`timescale 1ns/1ns
module bbd_core #(
    parameter int unsigned MC_CLKS = bbd_pkg::CLKS_PER_MC
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        START_IN,
    input  wire logic [7:0]  OPCODE_IN,
    input  wire logic [7:0]  BYTE2_IN,
    input  wire logic [7:0]  BYTE3_IN,
    input  wire logic [15:0] PC_IN,
    input  wire logic [1:0]  BANK_IN,
    input  wire logic [7:0]  R0_IN,
    input  wire logic [7:0]  R1_IN,
    input  wire logic [7:0]  ACC_IN,
    input  wire logic [15:0] DATA_POINTER_IN,
    input  wire logic        CARRY_IN,
    input  wire logic        BIT_IN,
    input  wire logic [7:0]  OPER_IN,
    input  wire logic [15:0] RET_ADDR_IN,
    output logic             READY_OUT,
    output logic             DONE_OUT,
    output logic             UNSUP_OUT,
    output logic [7:0]       OPER_ADDR_OUT,
    output logic             OPER_SFR_OUT,
    output logic [7:0]       BIT_ADDR_OUT,
    output logic [15:0]      PC_OUT,
    output logic             BRANCH_TAKEN_OUT,
    output logic             CARRY_OUT,
    output logic             CARRY_WE_OUT,
    output logic             BIT_VAL_OUT,
    output logic             BIT_WE_OUT,
    output logic [7:0]       BYTE_VAL_OUT,
    output logic             BYTE_WE_OUT,
    output logic             PUSH_OUT,
    output logic [15:0]      PUSH_ADDR_OUT,
    output logic             POP_OUT,
    output logic             PRIO_RELEASE_OUT
);

    typedef enum {ST_IDLE, ST_EXEC} bbd_state_t;

    function automatic bbd_pkg::bbd_class_t bbd_classify(
        input logic [7:0] op);
        bbd_pkg::bbd_class_t c;
        c = bbd_pkg::CL_UNSUP;
        if (op[3:0] == bbd_pkg::LOW_PAGE_OP)
            c = op[4] ? bbd_pkg::CL_PAGE_CALL
                      : bbd_pkg::CL_PAGE_BR;
        else if (op[7:3] == bbd_pkg::GRP_CMP_REG ||
                 op[7:1] == bbd_pkg::GRP_CMP_IND ||
                 op == bbd_pkg::OP_CMP_A_IMM ||
                 op == bbd_pkg::OP_CMP_A_DIR)
            c = bbd_pkg::CL_CMP;
        else if (op[7:3] == bbd_pkg::GRP_DEC_REG ||
                 op == bbd_pkg::OP_DEC_DIR)
            c = bbd_pkg::CL_DEC;
        else
            case (op)
                bbd_pkg::OP_NOP:         c = bbd_pkg::CL_NOP;
                bbd_pkg::OP_AND_C_BIT:   c = bbd_pkg::CL_AND_BIT;
                bbd_pkg::OP_AND_C_NBIT:  c = bbd_pkg::CL_AND_NBIT;
                bbd_pkg::OP_OR_C_BIT:    c = bbd_pkg::CL_OR_BIT;
                bbd_pkg::OP_OR_C_NBIT:   c = bbd_pkg::CL_OR_NBIT;
                bbd_pkg::OP_MOV_C_BIT:   c = bbd_pkg::CL_COPY_TO_C;
                bbd_pkg::OP_MOV_BIT_C:   c = bbd_pkg::CL_COPY_FROM_C;
                bbd_pkg::OP_SHORT_BR:    c = bbd_pkg::CL_SHORT;
                bbd_pkg::OP_JUMP_IND:    c = bbd_pkg::CL_IND_JUMP;
                bbd_pkg::OP_BR_A_ZERO:   c = bbd_pkg::CL_A_ZERO;
                bbd_pkg::OP_BR_A_NZ:     c = bbd_pkg::CL_A_NZ;
                bbd_pkg::OP_BR_C_ONE:    c = bbd_pkg::CL_C_ONE;
                bbd_pkg::OP_BR_C_ZERO:   c = bbd_pkg::CL_C_ZERO;
                bbd_pkg::OP_BR_BIT_ONE:  c = bbd_pkg::CL_BIT_ONE;
                bbd_pkg::OP_BR_BIT_ZERO: c = bbd_pkg::CL_BIT_ZERO;
                bbd_pkg::OP_BR_BIT_CLR:  c = bbd_pkg::CL_BIT_CLR;
                bbd_pkg::OP_FAR_CALL:    c = bbd_pkg::CL_FAR_CALL;
                bbd_pkg::OP_FAR_BRANCH:  c = bbd_pkg::CL_FAR_BR;
                bbd_pkg::OP_RETURN:      c = bbd_pkg::CL_RET;
                bbd_pkg::OP_INT_RETURN:  c = bbd_pkg::CL_INTERRUPT_RETURN;
                default:                 c = bbd_pkg::CL_UNSUP;
            endcase
        return c;
    endfunction

    // instruction length in bytes
    function automatic logic [1:0] bbd_length(input logic [7:0] op);
        bbd_pkg::bbd_class_t c;
        c = bbd_classify(op);
        case (c)
            bbd_pkg::CL_NOP, bbd_pkg::CL_IND_JUMP, bbd_pkg::CL_RET,
            bbd_pkg::CL_INTERRUPT_RETURN, bbd_pkg::CL_UNSUP: return 2'h1;
            bbd_pkg::CL_BIT_ONE, bbd_pkg::CL_BIT_ZERO, bbd_pkg::CL_BIT_CLR,
            bbd_pkg::CL_CMP, bbd_pkg::CL_FAR_CALL,
            bbd_pkg::CL_FAR_BR: return 2'h3;
            bbd_pkg::CL_DEC: return (op == bbd_pkg::OP_DEC_DIR) ? 2'h3
                                                                : 2'h2;
            default: return 2'h2;
        endcase
    endfunction

    // machine cycles; only the no-op, copy-to-carry and unsupported opcodes finish in one
    function automatic logic [1:0] bbd_cycles(input logic [7:0] op);
        bbd_pkg::bbd_class_t c;
        c = bbd_classify(op);
        if (c == bbd_pkg::CL_NOP || c == bbd_pkg::CL_COPY_TO_C ||
            c == bbd_pkg::CL_UNSUP)
            return 2'h1;
        return 2'h2;
    endfunction

    bbd_state_t          state_r;
    bbd_pkg::bbd_class_t cls_r;
    logic [7:0]          op_r;
    logic [7:0]          b2_r;
    logic [7:0]          b3_r;
    logic [15:0]         follow_r;
    logic [1:0]          mc_left_r;
    logic [15:0]         div_r;
    logic                tick;
    logic                last_tick;
    logic                take;

    logic [15:0]         pc_nxt;
    logic                taken_nxt;
    logic                c_nxt;
    logic                c_we_nxt;
    logic                bit_nxt;
    logic                bit_we_nxt;
    logic [7:0]          byte_nxt;
    logic                byte_we_nxt;
    logic [7:0]          rel;
    logic [15:0]         rel_target;
    logic [7:0]          dec_val;

    assign READY_OUT = (state_r == ST_IDLE);
    assign take      = START_IN && READY_OUT;
    assign tick      = (state_r == ST_EXEC) &&
                       (div_r == 16'(MC_CLKS - 1));
    assign last_tick = tick && (mc_left_r == 2'h1);

    // divider restarts on each instruction so timing is exact
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN)
            div_r <= 16'h0000;
        else if (take || tick)
            div_r <= 16'h0000;
        else if (state_r == ST_EXEC)
            div_r <= div_r + 16'h0001;
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_r   <= ST_IDLE;
            mc_left_r <= 2'h0;
        end else begin
            unique case (state_r)
                ST_IDLE: if (take) begin
                    state_r   <= ST_EXEC;
                    mc_left_r <= bbd_cycles(OPCODE_IN);
                end
                ST_EXEC: if (last_tick) begin
                    state_r   <= ST_IDLE;
                end else if (tick) begin
                    mc_left_r <= mc_left_r - 2'h1;
                end
            endcase
        end
    end

    // latch instruction and resolve operand addresses
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cls_r         <= bbd_pkg::CL_NOP;
            op_r          <= 8'h00;
            b2_r          <= 8'h00;
            b3_r          <= 8'h00;
            follow_r      <= 16'h0000;
            OPER_ADDR_OUT <= 8'h00;
            OPER_SFR_OUT  <= 1'b0;
            BIT_ADDR_OUT  <= 8'h00;
        end else if (take) begin
            cls_r        <= bbd_classify(OPCODE_IN);
            op_r         <= OPCODE_IN;
            b2_r         <= BYTE2_IN;
            b3_r         <= BYTE3_IN;
            follow_r     <= PC_IN + {14'h0000, bbd_length(OPCODE_IN)};
            BIT_ADDR_OUT <= BYTE2_IN;
            if (OPCODE_IN[3])
                OPER_ADDR_OUT <= {3'h0, BANK_IN,
                                  OPCODE_IN[2:0]};
            else if (OPCODE_IN[3:1] == 3'h3)
                OPER_ADDR_OUT <= OPCODE_IN[0] ? R1_IN
                                              : R0_IN;
            else
                OPER_ADDR_OUT <= BYTE2_IN;
            // direct bytes below the base are RAM, the base and above are registers
            OPER_SFR_OUT <= !OPCODE_IN[3] && (OPCODE_IN[3:1] != 3'h3) &&
                            (BYTE2_IN >= bbd_pkg::SFR_BASE);
        end
    end

    // three-byte forms carry the offset in byte three
    assign rel        = (bbd_length(op_r) == 2'h3) ? b3_r : b2_r;
    assign rel_target = follow_r + {{8{rel[7]}}, rel};
    assign dec_val    = OPER_IN - 8'h01;

    always_comb begin
        pc_nxt      = follow_r;
        taken_nxt   = 1'b0;
        c_nxt       = CARRY_IN;
        c_we_nxt    = 1'b0;
        bit_nxt     = 1'b0;
        bit_we_nxt  = 1'b0;
        byte_nxt    = 8'h00;
        byte_we_nxt = 1'b0;
        unique case (cls_r)
            bbd_pkg::CL_AND_BIT: begin
                c_nxt    = CARRY_IN & BIT_IN;
                c_we_nxt = 1'b1;
            end
            bbd_pkg::CL_AND_NBIT: begin
                c_nxt    = CARRY_IN & ~BIT_IN;
                c_we_nxt = 1'b1;
            end
            bbd_pkg::CL_OR_BIT: begin
                c_nxt    = CARRY_IN | BIT_IN;
                c_we_nxt = 1'b1;
            end
            bbd_pkg::CL_OR_NBIT: begin
                c_nxt    = CARRY_IN | ~BIT_IN;
                c_we_nxt = 1'b1;
            end
            bbd_pkg::CL_COPY_TO_C: begin
                c_nxt    = BIT_IN;
                c_we_nxt = 1'b1;
            end
            bbd_pkg::CL_COPY_FROM_C: begin
                bit_nxt    = CARRY_IN;
                bit_we_nxt = 1'b1;
            end
            bbd_pkg::CL_SHORT: taken_nxt = 1'b1;
            bbd_pkg::CL_IND_JUMP: begin
                taken_nxt = 1'b1;
                pc_nxt    = {8'h00, ACC_IN} + DATA_POINTER_IN;
            end
            bbd_pkg::CL_A_ZERO:   taken_nxt = (ACC_IN == 8'h00);
            bbd_pkg::CL_A_NZ:     taken_nxt = (ACC_IN != 8'h00);
            bbd_pkg::CL_C_ONE:    taken_nxt = CARRY_IN;
            bbd_pkg::CL_C_ZERO:   taken_nxt = !CARRY_IN;
            bbd_pkg::CL_BIT_ONE:  taken_nxt = BIT_IN;
            bbd_pkg::CL_BIT_ZERO: taken_nxt = !BIT_IN;
            bbd_pkg::CL_BIT_CLR: begin
                taken_nxt  = BIT_IN;
                bit_we_nxt = BIT_IN;
            end
            bbd_pkg::CL_CMP:
                // accumulator forms compare A, the others the fetched operand
                taken_nxt = (op_r[7:1] == 7'h5A)
                          ? ((op_r[0] ? OPER_IN : b2_r) != ACC_IN)
                          : (OPER_IN != b2_r);
            bbd_pkg::CL_DEC: begin
                byte_nxt    = dec_val;
                byte_we_nxt = 1'b1;
                taken_nxt   = (dec_val != 8'h00);
            end
            bbd_pkg::CL_FAR_CALL, bbd_pkg::CL_FAR_BR: begin
                taken_nxt = 1'b1;
                pc_nxt    = {b2_r, b3_r};
            end
            bbd_pkg::CL_PAGE_CALL, bbd_pkg::CL_PAGE_BR: begin
                taken_nxt = 1'b1;
                pc_nxt    = {follow_r[15:11], op_r[7:5], b2_r};
            end
            bbd_pkg::CL_RET, bbd_pkg::CL_INTERRUPT_RETURN: begin
                taken_nxt = 1'b1;
                pc_nxt    = RET_ADDR_IN;
            end
            default: ;
        endcase
        if (taken_nxt && (cls_r == bbd_pkg::CL_SHORT ||
            (cls_r >= bbd_pkg::CL_A_ZERO && cls_r <= bbd_pkg::CL_DEC)))
            pc_nxt = rel_target;
    end

    // results update once, at the end of the final machine cycle
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            DONE_OUT         <= 1'b0;
            UNSUP_OUT        <= 1'b0;
            PC_OUT           <= 16'h0000;
            BRANCH_TAKEN_OUT <= 1'b0;
            CARRY_OUT        <= 1'b0;
            CARRY_WE_OUT     <= 1'b0;
            BIT_VAL_OUT      <= 1'b0;
            BIT_WE_OUT       <= 1'b0;
            BYTE_VAL_OUT     <= 8'h00;
            BYTE_WE_OUT      <= 1'b0;
            PUSH_OUT         <= 1'b0;
            PUSH_ADDR_OUT    <= 16'h0000;
            POP_OUT          <= 1'b0;
            PRIO_RELEASE_OUT <= 1'b0;
        end else begin
            DONE_OUT         <= last_tick;
            UNSUP_OUT        <= last_tick && (cls_r == bbd_pkg::CL_UNSUP);
            CARRY_WE_OUT     <= last_tick && c_we_nxt;
            BIT_WE_OUT       <= last_tick && bit_we_nxt;
            BYTE_WE_OUT      <= last_tick && byte_we_nxt;
            PUSH_OUT         <= last_tick &&
                                (cls_r == bbd_pkg::CL_FAR_CALL ||
                                 cls_r == bbd_pkg::CL_PAGE_CALL);
            POP_OUT          <= last_tick && (cls_r == bbd_pkg::CL_RET ||
                                              cls_r == bbd_pkg::CL_INTERRUPT_RETURN);
            PRIO_RELEASE_OUT <= last_tick &&
                                (cls_r == bbd_pkg::CL_INTERRUPT_RETURN);
            if (last_tick) begin
                PC_OUT           <= pc_nxt;
                BRANCH_TAKEN_OUT <= taken_nxt;
                CARRY_OUT        <= c_nxt;
                BIT_VAL_OUT      <= bit_nxt;
                BYTE_VAL_OUT     <= byte_nxt;
                PUSH_ADDR_OUT    <= follow_r;
            end
        end
    end

    // helper: clocks since the instruction was taken
    logic [15:0] run_cnt_r;
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN)
            run_cnt_r <= 16'h0000;
        else if (take)
            run_cnt_r <= 16'h0000;
        else if (state_r == ST_EXEC)
            run_cnt_r <= run_cnt_r + 16'h0001;
    end

    sequence s_done_as(bbd_pkg::bbd_class_t c);
        DONE_OUT && cls_r == c;
    endsequence

    a_duration_exact: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN) DONE_OUT |->
        run_cnt_r == 16'(MC_CLKS * (
            (cls_r == bbd_pkg::CL_NOP || cls_r == bbd_pkg::CL_COPY_TO_C ||
             cls_r == bbd_pkg::CL_UNSUP) ? 1 : 2)))
        else $error("instruction took the wrong number of clocks");
    a_and_carry: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN) s_done_as(bbd_pkg::CL_AND_BIT) |->
        CARRY_WE_OUT && CARRY_OUT == $past(CARRY_IN & BIT_IN))
        else $error("carry and-with-bit wrong");
    a_or_ncarry: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN) s_done_as(bbd_pkg::CL_OR_NBIT) |->
        CARRY_OUT == $past(CARRY_IN | ~BIT_IN) && !BIT_WE_OUT)
        else $error("carry or-with-inverse wrong");
    a_bit_from_c: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN) s_done_as(bbd_pkg::CL_COPY_FROM_C) |->
        BIT_WE_OUT && BIT_VAL_OUT == $past(CARRY_IN) && !CARRY_WE_OUT)
        else $error("bit from carry wrong");
    a_rel_target: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN) s_done_as(bbd_pkg::CL_SHORT) |->
        PC_OUT == follow_r + {{8{b2_r[7]}}, b2_r} && BRANCH_TAKEN_OUT)
        else $error("short branch target wrong");
    a_bit_clear: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN) s_done_as(bbd_pkg::CL_BIT_CLR) |->
        BIT_WE_OUT == BRANCH_TAKEN_OUT && !BIT_VAL_OUT)
        else $error("branch-and-clear did not clear");
    a_dec_branch: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN) s_done_as(bbd_pkg::CL_DEC) |->
        BYTE_WE_OUT && BYTE_VAL_OUT == $past(OPER_IN) - 8'h01 &&
        BRANCH_TAKEN_OUT == (BYTE_VAL_OUT != 8'h00))
        else $error("decrement branch wrong");
    a_page_target: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN) DONE_OUT && (cls_r == bbd_pkg::CL_PAGE_CALL ||
        cls_r == bbd_pkg::CL_PAGE_BR) |->
        PC_OUT[15:11] == follow_r[15:11] && PC_OUT[7:0] == b2_r &&
        PUSH_OUT == op_r[4])
        else $error("page target or call push wrong");
    a_return_pop: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN) POP_OUT |->
        DONE_OUT && PC_OUT == $past(RET_ADDR_IN) &&
        PRIO_RELEASE_OUT == (cls_r == bbd_pkg::CL_INTERRUPT_RETURN))
        else $error("return handling wrong");
    a_nop_advance: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN) s_done_as(bbd_pkg::CL_NOP) |->
        PC_OUT == follow_r && !CARRY_WE_OUT && !BIT_WE_OUT)
        else $error("no-op changed state");

endmodule // bbd_core

// ==== bbd_pkg.sv ====
/*
 * bbd_pkg: constants and types shared by the boolean and branch
 * execution unit: opcodes, opcode groups, instruction classes, machine-cycle timing.
 * Assumes the enclosing core fetches all instruction bytes before start.
 */
package bbd_pkg;

    // oscillator clocks per machine cycle (plain default, adjustable)
    localparam int unsigned CLKS_PER_MC   = 12;

    localparam logic [7:0] OP_NOP         = 8'h00;
    localparam logic [7:0] OP_FAR_BRANCH  = 8'h02;
    localparam logic [7:0] OP_BR_BIT_CLR  = 8'h10;
    localparam logic [7:0] OP_FAR_CALL    = 8'h12;
    localparam logic [7:0] OP_BR_BIT_ONE  = 8'h20;
    localparam logic [7:0] OP_RETURN      = 8'h22;
    localparam logic [7:0] OP_BR_BIT_ZERO = 8'h30;
    localparam logic [7:0] OP_INT_RETURN  = 8'h32;
    localparam logic [7:0] OP_BR_C_ONE    = 8'h40;
    localparam logic [7:0] OP_BR_C_ZERO   = 8'h50;
    localparam logic [7:0] OP_BR_A_ZERO   = 8'h60;
    localparam logic [7:0] OP_BR_A_NZ     = 8'h70;
    localparam logic [7:0] OP_OR_C_BIT    = 8'h72;
    localparam logic [7:0] OP_JUMP_IND    = 8'h73;
    localparam logic [7:0] OP_SHORT_BR    = 8'h80;
    localparam logic [7:0] OP_AND_C_BIT   = 8'h82;
    localparam logic [7:0] OP_MOV_BIT_C   = 8'h92;
    localparam logic [7:0] OP_OR_C_NBIT   = 8'hA0;
    localparam logic [7:0] OP_MOV_C_BIT   = 8'hA2;
    localparam logic [7:0] OP_AND_C_NBIT  = 8'hB0;
    localparam logic [7:0] OP_CMP_A_IMM   = 8'hB4;
    localparam logic [7:0] OP_CMP_A_DIR   = 8'hB5;
    localparam logic [7:0] OP_DEC_DIR     = 8'hD5;

    // opcode groups by high bits (low nibble 8..F, 6/7), x1 by low nibble
    localparam logic [4:0] GRP_CMP_REG    = 5'h17;
    localparam logic [6:0] GRP_CMP_IND    = 7'h5B;
    localparam logic [4:0] GRP_DEC_REG    = 5'h1B;
    localparam logic [3:0] LOW_PAGE_OP    = 4'h1;

    localparam logic [7:0] SFR_BASE       = 8'h80;

    typedef enum {
        CL_NOP, CL_AND_BIT, CL_AND_NBIT, CL_OR_BIT, CL_OR_NBIT,
        CL_COPY_TO_C, CL_COPY_FROM_C, CL_SHORT, CL_IND_JUMP,
        CL_A_ZERO, CL_A_NZ, CL_C_ONE, CL_C_ZERO, CL_BIT_ONE,
        CL_BIT_ZERO, CL_BIT_CLR, CL_CMP, CL_DEC, CL_FAR_CALL,
        CL_FAR_BR, CL_PAGE_CALL, CL_PAGE_BR, CL_RET, CL_INTERRUPT_RETURN,
        CL_UNSUP
    } bbd_class_t;

endpackage

// ==== bbd_tb.sv ====
/* testbench: self-checking bench for bbd_core, one instruction at a time.
   assumes bbd_pkg and bbd_core compiled first; short machine cycle. */
`timescale 1ns/1ns
module testbench;
    localparam int unsigned MC = 2; // short machine cycle keeps the run brief
    logic        SYS_CLK_IN = 1'b0;
    logic        RST_IN = 1'b1;
    logic        START_IN = 1'b0;
    logic [7:0]  OPCODE_IN = 8'h00, BYTE2_IN = 8'h00, BYTE3_IN = 8'h00;
    logic [7:0]  R0_IN = 8'h44, R1_IN = 8'h55, ACC_IN = 8'h00, OPER_IN = 8'h00;
    logic [15:0] PC_IN = 16'h1000, DATA_POINTER_IN = 16'h0000, RET_ADDR_IN = 16'h0000;
    logic [1:0]  BANK_IN = 2'h2;
    logic        CARRY_IN = 1'b0, BIT_IN = 1'b0;
    logic        READY_OUT, DONE_OUT, UNSUP_OUT, OPER_SFR_OUT, BRANCH_TAKEN_OUT;
    logic        CARRY_OUT, CARRY_WE_OUT, BIT_VAL_OUT, BIT_WE_OUT, BYTE_WE_OUT;
    logic        PUSH_OUT, POP_OUT, PRIO_RELEASE_OUT;
    logic [7:0]  OPER_ADDR_OUT, BIT_ADDR_OUT, BYTE_VAL_OUT;
    logic [15:0] PC_OUT, PUSH_ADDR_OUT;
    int          err_total = 0, check_count = 0, cyc = 0;
    bbd_core #(.MC_CLKS(MC)) bbd_core_inst (.*);
    always #50 SYS_CLK_IN = ~SYS_CLK_IN;
    always @(posedge SYS_CLK_IN) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            summarize();
        end
    end
    task automatic summarize();
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(string nm, logic e, logic g);
        chk(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    // entered at a falling edge with READY_OUT high; operands stay put
    task automatic exec(logic [7:0] op, b2, b3, int n);
        int k;
        OPCODE_IN = op;
        BYTE2_IN = b2;
        BYTE3_IN = b3;
        START_IN = 1'b1;
        @(negedge SYS_CLK_IN);
        START_IN = 1'b0;
        k = 0;
        while (DONE_OUT !== 1'b1 && k < 80) begin
            @(negedge SYS_CLK_IN);
            k++;
        end
        chk("cycles", 16'(n * MC), 16'(k));
    endtask
    task automatic br(logic [7:0] op, b2, b3, int len, logic tk);
        logic [7:0]  off;
        logic [15:0] nx;
        off = (len == 3) ? b3 : b2;
        nx = PC_IN + 16'(len);
        exec(op, b2, b3, 2);
        chk1("taken", tk, BRANCH_TAKEN_OUT);
        chk("pc", tk ? nx + {{8{off[7]}}, off} : nx, PC_OUT);
    endtask
    task automatic t_bool();
        for (int i = 0; i < 4; i++) begin
            CARRY_IN = i[1];
            BIT_IN = i[0];
            exec(8'h82, 8'h2F, 8'h00, 2);
            chk1("and", i[1] & i[0], CARRY_OUT);
            chk("pc", 16'h1002, PC_OUT);
            exec(8'hB0, 8'h2F, 8'h00, 2);
            chk1("andn", i[1] & ~i[0], CARRY_OUT);
            chk1("bwe", 1'b0, BIT_WE_OUT);
            exec(8'h72, 8'h2F, 8'h00, 2);
            chk1("or", i[1] | i[0], CARRY_OUT);
            exec(8'hA0, 8'h2F, 8'h00, 2);
            chk1("orn", i[1] | ~i[0], CARRY_OUT);
            chk1("bwe", 1'b0, BIT_WE_OUT);
            exec(8'hA2, 8'h2F, 8'h00, 1);
            chk1("mov", i[0], CARRY_OUT);
            chk1("cwe", 1'b1, CARRY_WE_OUT);
            exec(8'h92, 8'h2F, 8'h00, 2);
            chk1("bval", i[1], BIT_VAL_OUT);
            chk("badr", 16'h002F, {8'h00, BIT_ADDR_OUT});
        end
    endtask
    task automatic t_branch();
        for (int i = 0; i < 2; i++) begin
            ACC_IN = i[0] ? 8'h00 : 8'h5A;
            CARRY_IN = i[0];
            BIT_IN = i[0];
            br(8'h60, 8'h80, 8'h00, 2, i[0]);
            br(8'h70, 8'h7F, 8'h00, 2, !i[0]);
            br(8'h40, 8'hF0, 8'h00, 2, i[0]);
            br(8'h50, 8'h10, 8'h00, 2, !i[0]);
            br(8'h20, 8'h2F, 8'hF0, 3, i[0]);
            br(8'h30, 8'h2F, 8'h7F, 3, !i[0]);
            br(8'h10, 8'h2F, 8'h05, 3, i[0]);
            chk1("clr", i[0], BIT_WE_OUT);
        end
        br(8'h80, 8'hFE, 8'h00, 2, 1'b1);
    endtask
    task automatic t_cmp();
        ACC_IN = 8'h33;
        OPER_IN = 8'h33;
        br(8'hB5, 8'h90, 8'h10, 3, 1'b0);
        chk1("sfr", 1'b1, OPER_SFR_OUT);
        br(8'hB4, 8'h34, 8'h10, 3, 1'b1);
        for (int r = 0; r < 8; r++) begin
            br(8'hB8 + 8'(r), 8'h33, 8'hF0, 3, 1'b0);
            chk("reg", {11'h000, 2'h2, 3'(r)}, 16'(OPER_ADDR_OUT));
        end
        for (int r = 0; r < 2; r++) begin
            br(8'hB6 + 8'(r), 8'h34, 8'h08, 3, 1'b1);
            chk("ind", r ? 16'h0055 : 16'h0044, 16'(OPER_ADDR_OUT));
        end
    endtask
    task automatic t_dec();
        BANK_IN = 2'h1;
        for (int v = 1; v < 6; v += 4) begin
            OPER_IN = 8'(v);
            br(8'hDB, 8'h10, 8'h00, 2, v != 1);
            chk("dec", 16'(v - 1), {8'h00, BYTE_VAL_OUT});
            chk("reg", 16'h000B, 16'(OPER_ADDR_OUT));
            br(8'hD5, 8'h40, 8'h20, 3, v != 1);
            chk1("bwe", 1'b1, BYTE_WE_OUT);
        end
    endtask
    task automatic t_jump();
        PC_IN = 16'h07FF;
        ACC_IN = 8'hF0;
        DATA_POINTER_IN = 16'h1234;
        RET_ADDR_IN = 16'h4321;
        exec(8'h02, 8'h12, 8'h34, 2);
        chk("far", 16'h1234, PC_OUT);
        exec(8'h12, 8'hAB, 8'hCD, 2);
        chk("fcall", 16'hABCD, PC_OUT);
        chk("push", 16'h0802, PUSH_ADDR_OUT);
        exec(8'hF1, 8'h56, 8'h00, 2);
        chk("page", 16'h0F56, PC_OUT);
        chk("push", 16'h0801, PUSH_ADDR_OUT);
        exec(8'h41, 8'h56, 8'h00, 2);
        chk("pgbr", 16'h0A56, PC_OUT);
        chk1("nopush", 1'b0, PUSH_OUT);
        exec(8'h73, 8'h00, 8'h00, 2);
        chk("ind", 16'h1324, PC_OUT);
        exec(8'h22, 8'h00, 8'h00, 2);
        chk("ret", 16'h4321, PC_OUT);
        chk1("prio", 1'b0, PRIO_RELEASE_OUT);
        chk1("pop", 1'b1, POP_OUT);
        exec(8'h32, 8'h00, 8'h00, 2);
        chk1("prio", 1'b1, PRIO_RELEASE_OUT);
        exec(8'h00, 8'h00, 8'h00, 1);
        chk("nop", 16'h0800, PC_OUT);
        chk1("unsup", 1'b0, UNSUP_OUT);
        chk1("nopop", 1'b0, POP_OUT);
    endtask
    initial begin
        repeat (6) @(negedge SYS_CLK_IN);
        RST_IN = 1'b0;
        @(negedge SYS_CLK_IN);
        t_bool();
        t_branch();
        t_cmp();
        t_dec();
        t_jump();
        summarize();
    end
endmodule // testbench
